//--- hdl/lhcp_host_port.sv
// Host control port: serial and multiplexed parallel access, interrupt pin,
// hardware-mode pin decode. Assumes all pins are asynchronous to sys_clk_in.
`timescale 1ns/1ns
module lhcp_host_port
  import lhcp_pkg::*;
#(
  parameter int NUM_SRC = 16
) (
  input  wire logic               sys_clk_in,
  input  wire logic               rst_in,
  input  wire logic [1:0]         if_mode_in,
  input  wire logic               cs_n_in,
  input  wire logic               sclk_in,
  input  wire logic               shift_edge_sel_in,
  input  wire logic               serial_in,
  output logic                    serial_out_out,
  output logic                    serial_out_oe_out,
  input  wire logic [7:0]         ad_in,
  output logic      [7:0]         ad_out,
  output logic                    ad_oe_out,
  input  wire logic               rd_n_in,
  input  wire logic               wr_n_in,
  input  wire logic               ale_in,
  input  wire logic               m_style_data_strobe_n_in,
  input  wire logic               m_style_dir_in,
  input  wire logic               m_style_addr_strobe_in,
  output logic                    rdy_out,
  output logic                    ack_n_out,
  output logic                    irq_out,
  output logic                    irq_oe_out,
  input  wire logic [NUM_SRC-1:0] irq_src_in,
  input  wire logic [1:0]         path_mode_pins_in,
  input  wire logic [1:0]         loopback_sel_in,
  output lhcp_path_s              path_out
);
  logic [14:0]        pin_s;
  logic [7:0]         ad_s;
  logic [3:0]         hw_s;
  logic               cs_n_s, sclk_s, edge_s, sdi_s;
  logic               rd_n_s, wr_n_s, ale_s, ds_n_s, dir_s, as_s;
  logic               sclk_d_r, ale_d_r, as_d_r;
  logic               sel_active;
  logic               strobe_lo;
  logic               is_read;
  logic [7:0]         addr_r;
  logic [7:0]         rdata_r;
  logic               busy_r;
  logic               done_r;
  logic               rd_cyc_r;
  logic [7:0]         cnt_r;
  logic [7:0]         gcfg_r;
  logic [15:0]        mask_r;
  logic [15:0]        flags_r;
  logic [15:0]        flags_nxt;
  logic [15:0]        clr_rd;
  logic [7:0]         rdata;
  logic               pend;
  lhcp_req_s          ser_req;
  lhcp_req_s          par_req;
  lhcp_req_s          req;
  lhcp_path_s         path_nxt;

  // ==========================================================
  // Pin synchronisers
  lhcp_sync #(.W(15)) u_sync_ctl (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .d_in       ({cs_n_in, sclk_in, shift_edge_sel_in, serial_in, rd_n_in, wr_n_in,
                  ale_in, m_style_data_strobe_n_in, m_style_dir_in, m_style_addr_strobe_in,
                  path_mode_pins_in, loopback_sel_in, 1'b0}),
    .q_out      (pin_s)
  );
  lhcp_sync #(.W(8)) u_sync_ad (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .d_in       (ad_in),
    .q_out      (ad_s)
  );
  assign {cs_n_s, sclk_s, edge_s, sdi_s, rd_n_s, wr_n_s, ale_s, ds_n_s, dir_s, as_s} = pin_s[14:5];
  assign hw_s = pin_s[4:1];

  // Previous levels for edge detection on synchronised pins
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      sclk_d_r <= 1'b0;
      ale_d_r  <= 1'b0;
      as_d_r   <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      ale_d_r  <= ale_s;
      as_d_r   <= as_s;
    end
  end

  // Select gates every access interface; high select leaves them idle, the interrupt pin still drives
  assign sel_active = !cs_n_s && (if_mode_in != IF_HARDWARE);

  // ==========================================================
  // Serial front end
  lhcp_serial u_serial (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .active_in   (sel_active && if_mode_in == IF_SERIAL),
    .rise_in     (sclk_s && !sclk_d_r),
    .fall_in     (!sclk_s && sclk_d_r),
    .sdi_in      (sdi_s),
    .edge_sel_in (edge_s),
    .rdata_in    (rdata),
    .req_out     (ser_req),
    .sdo_out     (serial_out_out)
  );
  // Output drive only while selected in serial style
  assign serial_out_oe_out = sel_active && if_mode_in == IF_SERIAL;

  // ==========================================================
  // Parallel address capture on falling latch edges
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      addr_r <= 8'h00;
    else if (sel_active && if_mode_in == IF_STROBE && ale_d_r && !ale_s)
      addr_r <= ad_s;
    else if (sel_active && if_mode_in == IF_M_STYLE && as_d_r && !as_s)
      addr_r <= ad_s;
  end

  // Strobe and direction per style
  always_comb
  begin
    strobe_lo = 1'b0;
    is_read   = 1'b0;
    if (if_mode_in == IF_STROBE)
    begin
      strobe_lo = !rd_n_s || !wr_n_s;
      is_read   = !rd_n_s;
    end
    else if (if_mode_in == IF_M_STYLE)
    begin
      strobe_lo = !ds_n_s;
      is_read   = dir_s;
    end
  end

  // ==========================================================
  // Parallel access sequencer: wait, act once, hold until strobe ends
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || !(sel_active && strobe_lo))
    begin
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      rd_cyc_r <= 1'b0;
      cnt_r    <= 8'h00;
    end
    else if (!busy_r)
    begin
      busy_r   <= 1'b1;
      rd_cyc_r <= is_read;
      cnt_r    <= 8'(ACCESS_CYC - 1);
    end
    else if (!done_r)
    begin
      if (cnt_r == 8'h00)
        done_r <= 1'b1;
      else
        cnt_r <= cnt_r - 8'h01;
    end
  end

  // Request fires on the cycle the wait expires
  always_comb
  begin
    par_req       = '0;
    par_req.addr  = addr_r;
    par_req.wdata = ad_s;
    if (busy_r && !done_r && cnt_r == 8'h00)
    begin
      par_req.rd = rd_cyc_r;
      par_req.wr = !rd_cyc_r;
    end
  end
  assign req = (if_mode_in == IF_SERIAL) ? ser_req : par_req;

  // Read data held for the bus drive
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      rdata_r <= 8'h00;
    else if (par_req.rd)
      rdata_r <= rdata;
  end
  assign ad_out    = rdata_r;
  // Bus driven only while the read strobe is still low
  assign ad_oe_out = busy_r && done_r && rd_cyc_r;
  // Ready low while the wait counts, high otherwise
  assign rdy_out   = !(if_mode_in == IF_STROBE && busy_r && !done_r);
  // Acknowledge low once the access has been performed
  assign ack_n_out = !(if_mode_in == IF_M_STYLE && busy_r && done_r);

  // ==========================================================
  // Register read mux; unmapped addresses read zero
  always_comb
  begin
    case (req.addr)
      ADDR_GLOBAL_CONFIG:  rdata = gcfg_r;
      ADDR_IRQ_MASK_LOW:   rdata = mask_r[7:0];
      ADDR_IRQ_MASK_HIGH:  rdata = mask_r[15:8];
      ADDR_IRQ_FLAGS_LOW:  rdata = flags_r[7:0];
      ADDR_IRQ_FLAGS_HIGH: rdata = flags_r[15:8];
      default:             rdata = 8'h00;
    endcase
  end

  // Writable registers
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      gcfg_r <= RST_GLOBAL_CONFIG;
      mask_r <= {RST_IRQ_MASK, RST_IRQ_MASK};
    end
    else if (req.wr)
    begin
      if (req.addr == ADDR_GLOBAL_CONFIG)
        gcfg_r <= req.wdata;
      if (req.addr == ADDR_IRQ_MASK_LOW)
        mask_r[7:0] <= req.wdata;
      if (req.addr == ADDR_IRQ_MASK_HIGH)
        mask_r[15:8] <= req.wdata;
    end
  end

  // ==========================================================
  // Sticky flags, cleared by reading; a new event beats the clear
  always_comb
  begin
    clr_rd = 16'h0000;
    if (req.rd && req.addr == ADDR_IRQ_FLAGS_LOW)
      clr_rd[7:0] = 8'hff;
    if (req.rd && req.addr == ADDR_IRQ_FLAGS_HIGH)
      clr_rd[15:8] = 8'hff;
    flags_nxt = (flags_r & ~clr_rd) | 16'(irq_src_in);
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      flags_r <= 16'h0000;
    else
      flags_r <= flags_nxt;
  end

  // Mask bit high blocks its source; drops when nothing unmasked remains
  assign pend = |(flags_r & ~mask_r);

  // Interrupt pin drive style
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || if_mode_in == IF_HARDWARE)
    begin
      irq_out    <= 1'b0;
      irq_oe_out <= 1'b0;
    end
    else
    begin
      case (gcfg_r[GC_IRQ_DRIVE_LSB +: 2])
        IRQ_PP_HIGH:
        begin
          irq_out    <= pend;
          irq_oe_out <= 1'b1;
        end
        IRQ_PP_LOW:
        begin
          irq_out    <= !pend;
          irq_oe_out <= 1'b1;
        end
        default:
        begin
          irq_out    <= 1'b0;
          irq_oe_out <= pend;
        end
      endcase
    end
  end

  // ==========================================================
  // Path and loopback decode from pins or from configuration
  always_comb
  begin
    lhcp_path_e pm;
    pm = lhcp_path_e'(hw_s[3:2]);
    path_nxt.loop      = lhcp_loop_e'(hw_s[1:0]);
    path_nxt.inband_ok = 1'b0;
    if (if_mode_in != IF_HARDWARE)
    begin
      pm                 = lhcp_path_e'(gcfg_r[GC_PATH_LSB +: 2]);
      path_nxt.loop      = lhcp_loop_e'(gcfg_r[GC_LOOP_LSB +: 2]);
      path_nxt.inband_ok = 1'b1;
    end
    case (pm)
      LHCP_PATH_SR_HDB3: {path_nxt.single_rail, path_nxt.ami, path_nxt.cdr_en} = 3'b101;
      LHCP_PATH_SR_AMI:  {path_nxt.single_rail, path_nxt.ami, path_nxt.cdr_en} = 3'b111;
      LHCP_PATH_DR_CDR:  {path_nxt.single_rail, path_nxt.ami, path_nxt.cdr_en} = 3'b001;
      default:           {path_nxt.single_rail, path_nxt.ami, path_nxt.cdr_en} = 3'b000;
    endcase
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      path_out <= '0;
    else
      path_out <= path_nxt;
  end
endmodule : lhcp_host_port

//--- hdl/lhcp_pkg.sv
// Shared constants and types of the host control port.
// Assumes a 250 MHz system clock and synchronous active-high reset.
package lhcp_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_GLOBAL_CONFIG  = 8'h02;
  localparam logic [7:0] ADDR_IRQ_MASK_LOW   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK_HIGH  = 8'h15;
  localparam logic [7:0] ADDR_IRQ_FLAGS_LOW  = 8'h19;
  localparam logic [7:0] ADDR_IRQ_FLAGS_HIGH = 8'h1a;
  localparam logic [7:0] RST_GLOBAL_CONFIG   = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK        = 8'h00;
  // ==========================================================
  // Field positions inside global_config
  localparam int GC_IRQ_DRIVE_LSB = 0;
  localparam int GC_PATH_LSB      = 2;
  localparam int GC_LOOP_LSB      = 4;
  // ==========================================================
  // Interface style on the mode pins
  localparam logic [1:0] IF_HARDWARE = 2'h0;
  localparam logic [1:0] IF_SERIAL   = 2'h1;
  localparam logic [1:0] IF_M_STYLE  = 2'h2;
  localparam logic [1:0] IF_STROBE   = 2'h3;
  // Interrupt drive styles
  localparam logic [1:0] IRQ_PP_HIGH = 2'h0;
  localparam logic [1:0] IRQ_PP_LOW  = 2'h1;
  // ==========================================================
  // Timing: parallel access latency
  localparam int CLK_PERIOD_NS = 4;
  localparam int ACCESS_NS     = 40;
  localparam int ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // Path and loopback encodings
  typedef enum logic [1:0] {
    LHCP_PATH_SR_HDB3 = 2'h0,
    LHCP_PATH_SR_AMI  = 2'h1,
    LHCP_PATH_DR_CDR  = 2'h2,
    LHCP_PATH_SLICER  = 2'h3
  } lhcp_path_e;
  typedef enum logic [1:0] {
    LHCP_LOOP_NONE    = 2'h0,
    LHCP_LOOP_ANALOG  = 2'h1,
    LHCP_LOOP_DIGITAL = 2'h2,
    LHCP_LOOP_REMOTE  = 2'h3
  } lhcp_loop_e;
  // Register request from any access front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lhcp_req_s;
  // Decoded line path settings
  typedef struct packed {
    logic       single_rail;
    logic       ami;
    logic       cdr_en;
    lhcp_loop_e loop;
    logic       inband_ok;
  } lhcp_path_s;
endpackage : lhcp_pkg

//--- hdl/lhcp_sync.sv
// Two-stage synchroniser for a bus of independent levels.
// Assumes each bit is quasi-static or a slow level from a pin.
`timescale 1ns/1ns
module lhcp_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  // ==========================================================
  // Meta stage feeds only the second stage; runs free so that reset
  // flushes real pin levels through, since a cleared stage would fake
  // active-low selects and strobes for two cycles after release
  always_ff @(posedge sys_clk_in)
  begin
    meta_r <= d_in;
    q_out  <= meta_r;
  end
endmodule : lhcp_sync

//--- hdl/lhcp_serial.sv
// Serial front end: command byte (read flag, 7-bit address), then a data byte.
// Assumes synchronised shift clock edges as one-cycle pulses on sys_clk_in.
`timescale 1ns/1ns
module lhcp_serial
  import lhcp_pkg::*;
(
  input  wire logic      sys_clk_in,
  input  wire logic      rst_in,
  input  wire logic      active_in,
  input  wire logic      rise_in,
  input  wire logic      fall_in,
  input  wire logic      sdi_in,
  input  wire logic      edge_sel_in,
  input  wire logic [7:0] rdata_in,
  output lhcp_req_s      req_out,
  output logic           sdo_out
);
  logic [3:0] bit_cnt_r;
  logic [7:0] cmd_r;
  logic [6:0] data_r;
  logic [7:0] out_r;
  logic       first_r;
  logic       out_edge;
  // Output edge follows the edge select level
  assign out_edge = edge_sel_in ? fall_in : rise_in;
  assign sdo_out  = out_r[7];
  // ==========================================================
  // Input shifting on rising edges
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || !active_in)
    begin
      bit_cnt_r <= 4'h0;
      cmd_r     <= 8'h00;
      data_r    <= 7'h00;
    end
    else if (rise_in)
    begin
      if (bit_cnt_r < 4'h8)
        cmd_r <= {cmd_r[6:0], sdi_in};
      else
        data_r <= {data_r[5:0], sdi_in};
      if (bit_cnt_r != 4'hf)
        bit_cnt_r <= bit_cnt_r + 4'h1;
      else
        bit_cnt_r <= 4'h0;
    end
  end
  // ==========================================================
  // Requests: read after the command, write after the data byte
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      req_out <= '0;
    else
    begin
      req_out.rd    <= active_in && rise_in && bit_cnt_r == 4'h7 && cmd_r[6];
      req_out.wr    <= active_in && rise_in && bit_cnt_r == 4'hf && !cmd_r[7];
      req_out.wdata <= {data_r, sdi_in};
      if (active_in && rise_in && bit_cnt_r == 4'h7)
        req_out.addr <= {1'b0, cmd_r[5:0], sdi_in};
    end
  end
  // ==========================================================
  // Output shifter; rising mode presents bit 7 at the load itself
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || !active_in)
    begin
      out_r   <= 8'h00;
      first_r <= 1'b0;
    end
    else if (req_out.rd)
    begin
      out_r   <= rdata_in;
      first_r <= edge_sel_in;
    end
    else if (out_edge)
    begin
      if (first_r)
        first_r <= 1'b0;
      else
        out_r <= {out_r[6:0], 1'b0};
    end
  end
endmodule : lhcp_serial

//--- testbench/lhcp_host_port_monitor.sv
// Concurrent checks on the pins of the host control port.
// Assumes the interface mode pins change only while reset is held.
`timescale 1ns/1ns
module lhcp_host_port_monitor
  import lhcp_pkg::*;
(
  input wire logic       sys_clk_in,
  input wire logic       rst_in,
  input wire logic [1:0] if_mode_in,
  input wire logic       cs_n_in,
  input wire logic       rd_n_in,
  input wire logic       wr_n_in,
  input wire logic       m_style_data_strobe_n_in,
  input wire logic [1:0] path_mode_pins_in,
  input wire logic [1:0] loopback_sel_in,
  input wire logic       serial_out_oe_out,
  input wire logic       ad_oe_out,
  input wire logic       rdy_out,
  input wire logic       ack_n_out,
  input wire logic       irq_oe_out,
  input wire lhcp_path_s path_out
);
  // ==========================================================
  // Clocking and step sequences
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  // Access wait, then ready returns
  sequence s_wait_done;
    !rdy_out [*8] ##[1:6] rdy_out;
  endsequence
  // Pins long enough still for two sync stages and the output flop
  sequence s_pins_held;
    (if_mode_in == IF_HARDWARE && $stable(path_mode_pins_in) && $stable(loopback_sel_in)) [*6];
  endsequence
  // ==========================================================
  // Assertions
  desel_quiet_a: assert property (cs_n_in [*5] |-> !ad_oe_out && !serial_out_oe_out && ack_n_out && rdy_out)
    else $error("port drives while deselected");
  serial_oe_a: assert property (serial_out_oe_out |-> if_mode_in == IF_SERIAL)
    else $error("serial output enabled outside serial mode");
  ready_wait_a: assert property ($fell(rdy_out) |-> s_wait_done)
    else $error("ready low time wrong");
  ready_cause_a: assert property (!rdy_out |-> if_mode_in == IF_STROBE && !(rd_n_in && wr_n_in))
    else $error("ready low without a strobe");
  rd_release_a: assert property ((if_mode_in == IF_STROBE && rd_n_in) [*4] |-> !ad_oe_out)
    else $error("bus driven after read strobe");
  ack_cause_a: assert property ($fell(ack_n_out) |-> if_mode_in == IF_M_STYLE && $past(m_style_data_strobe_n_in, 8) == 1'b0)
    else $error("acknowledge without long data strobe");
  ds_release_a: assert property (m_style_data_strobe_n_in [*5] |-> ack_n_out)
    else $error("acknowledge held after data strobe");
  irq_hw_a: assert property (if_mode_in == IF_HARDWARE |-> !irq_oe_out)
    else $error("interrupt driven in hardware mode");
  hw_path_a: assert property (s_pins_held |-> path_out.single_rail == !path_mode_pins_in[1] && path_out.loop == loopback_sel_in && !path_out.inband_ok)
    else $error("hardware pin decode wrong");
endmodule : lhcp_host_port_monitor

bind lhcp_host_port lhcp_host_port_monitor u_mon (.sys_clk_in, .rst_in, .if_mode_in, .cs_n_in, .rd_n_in, .wr_n_in,
  .m_style_data_strobe_n_in, .path_mode_pins_in, .loopback_sel_in, .serial_out_oe_out, .ad_oe_out, .rdy_out,
  .ack_n_out, .irq_oe_out, .path_out);

//--- testbench/lhcp_host_model.sv
// Host microcontroller model: serial frames and both multiplexed bus styles.
// Assumes the caller picks the style; bus level is resolved here.
`timescale 1ns/1ns
module lhcp_host_model (
  input  wire logic       clk_in,
  input  wire logic       rdy_in,
  input  wire logic       ack_n_in,
  input  wire logic       sdo_in,
  input  wire logic       oe_in,
  input  wire logic [7:0] dev_in,
  output logic            cs_n_out,
  output logic            sclk_out,
  output logic            sdi_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic            ale_out,
  output logic            as_out,
  output logic            ds_n_out,
  output logic            dir_out,
  output logic [7:0]      bus_out
);
  logic [7:0] hd;
  // Released bus shows the inverse of the last host value
  assign bus_out = oe_in ? dev_in : hd;
  initial
  begin
    {cs_n_out, rd_n_out, wr_n_out, ds_n_out} = 4'hf;
    {sclk_out, sdi_out, ale_out, as_out, dir_out} = 5'h00;
    hd = 8'h00;
  end
  // ==========================================================
  // Parallel access; m selects the direction-select style
  task automatic acc(input logic m, w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    hd <= a;
    ale_out <= !m;
    as_out <= m;
    dir_out <= !w;
    @(posedge clk_in);
    ale_out <= 1'b0;
    as_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    hd <= w ? d : ~a;
    ds_n_out <= !m;
    wr_n_out <= m || !w;
    rd_n_out <= m || w;
    for (int n = 0; n < 40 && (m ? ack_n_in !== 1'b0 : rdy_in !== 1'b0); n++) @(posedge clk_in);
    for (int n = 0; n < 40 && !m && rdy_in !== 1'b1; n++) @(posedge clk_in);
    q = (m ? ack_n_in === 1'b0 : rdy_in === 1'b1) ? bus_out : 8'hxx;
    {cs_n_out, rd_n_out, wr_n_out, ds_n_out} <= 4'hf;
    hd <= ~hd;
    repeat (6) @(posedge clk_in);
  endtask : acc
  // ==========================================================
  // Serial frame, 125 ns shift clock, still outside the frame
  task automatic ser(input logic c, w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {!w, a, d};
    @(posedge clk_in);
    cs_n_out <= c;
    #30;
    // Non-blocking: the 125 ns phase drifts onto clock edges
    for (int i = 15; i >= 0; i--)
    begin
      sdi_out <= f[i];
      #62;
      if (i < 8) q[i] = sdo_in;
      sclk_out <= 1'b1;
      #63;
      sclk_out <= 1'b0;
    end
    #30;
    sdi_out <= !sdi_out;
    @(posedge clk_in);
    cs_n_out <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask : ser
endmodule : lhcp_host_model

//--- testbench/lhcp_host_port_tb_top.sv
// Self-checking bench of the host control port, one mode per reset.
// Assumes the host model and the bound pin checker.
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module lhcp_host_port_tb_top
  import lhcp_pkg::*;
();
  logic        sys_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [1:0]  if_mode_in = IF_HARDWARE;
  logic        shift_edge_sel_in = 1'b0;
  logic [15:0] irq_src_in = 16'h0000;
  logic [1:0]  path_mode_pins_in = 2'h0;
  logic [1:0]  loopback_sel_in = 2'h0;
  wire         cs_n_in, sclk_in, serial_in, rd_n_in, wr_n_in, ale_in;
  wire         m_style_data_strobe_n_in, m_style_dir_in, m_style_addr_strobe_in;
  wire  [7:0]  ad_in;
  logic [7:0]  ad_out, q;
  logic        serial_out_out, serial_out_oe_out, ad_oe_out, rdy_out, ack_n_out, irq_out, irq_oe_out;
  lhcp_path_s  path_out;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  // ==========================================================
  // Clock, design, host and hang guard
  always #2 sys_clk_in = ~sys_clk_in;
  lhcp_host_port dut (.sys_clk_in, .rst_in, .if_mode_in, .cs_n_in, .sclk_in, .shift_edge_sel_in, .serial_in,
    .serial_out_out, .serial_out_oe_out, .ad_in, .ad_out, .ad_oe_out, .rd_n_in, .wr_n_in, .ale_in,
    .m_style_data_strobe_n_in, .m_style_dir_in, .m_style_addr_strobe_in, .rdy_out, .ack_n_out, .irq_out,
    .irq_oe_out, .irq_src_in, .path_mode_pins_in, .loopback_sel_in, .path_out);
  lhcp_host_model h (.clk_in(sys_clk_in), .rdy_in(rdy_out), .ack_n_in(ack_n_out), .sdo_in(serial_out_out),
    .oe_in(ad_oe_out), .dev_in(ad_out), .cs_n_out(cs_n_in), .sclk_out(sclk_in), .sdi_out(serial_in),
    .rd_n_out(rd_n_in), .wr_n_out(wr_n_in), .ale_out(ale_in), .as_out(m_style_addr_strobe_in),
    .ds_n_out(m_style_data_strobe_n_in), .dir_out(m_style_dir_in), .bus_out(ad_in));
  // Whole run needs some 4000 cycles
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      test_done();
    end
  end
  // ==========================================================
  // Helpers
  task automatic test_done();
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // Mode pins are static, so they only move under reset
  task automatic boot(input logic [1:0] m);
    rst_in <= 1'b1;
    if_mode_in <= m;
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
  endtask : boot
  task automatic wr(input logic [7:0] a, d);
    if (if_mode_in == IF_SERIAL) h.ser(1'b0, 1'b1, a[6:0], d, q);
    else h.acc(if_mode_in == IF_M_STYLE, 1'b1, a, d, q);
  endtask : wr
  task automatic chk_rd(input logic [7:0] a, e);
    if (if_mode_in == IF_SERIAL) h.ser(1'b0, 1'b0, a[6:0], 8'h00, q);
    else h.acc(if_mode_in == IF_M_STYLE, 1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask : chk_rd
  task automatic pulse(input logic [15:0] v);
    @(posedge sys_clk_in) irq_src_in <= v;
    @(posedge sys_clk_in) irq_src_in <= 16'h0000;
    repeat (3) @(posedge sys_clk_in);
  endtask : pulse
  function automatic lhcp_path_s ep(input logic [1:0] p, l, input logic ib);
    ep = '{~p[1], p == 2'h1, p != 2'h3, lhcp_loop_e'(l), ib};
  endfunction : ep
  // ==========================================================
  // Scenarios
  initial
  begin
    boot(IF_HARDWARE);
    for (int i = 0; i < 16; i++)
    begin
      path_mode_pins_in <= i[3:2];
      loopback_sel_in <= i[1:0];
      repeat (8) @(posedge sys_clk_in);
      `CHK(path_out, ep(i[3:2], i[1:0], 1'b0))
      `CHK(irq_oe_out, 1'b0)
    end
    boot(IF_STROBE);
    chk_rd(ADDR_GLOBAL_CONFIG, RST_GLOBAL_CONFIG);
    chk_rd(ADDR_IRQ_MASK_HIGH, RST_IRQ_MASK);
    chk_rd(8'h07, 8'h00);
    wr(ADDR_IRQ_FLAGS_LOW, 8'hff);
    chk_rd(ADDR_IRQ_FLAGS_LOW, 8'h00);
    wr(ADDR_IRQ_MASK_LOW, 8'hff);
    wr(ADDR_IRQ_MASK_HIGH, 8'hff);
    pulse(16'h0201);
    `CHK({irq_out, irq_oe_out}, 2'b01)
    chk_rd(ADDR_IRQ_FLAGS_LOW, 8'h01);
    chk_rd(ADDR_IRQ_FLAGS_HIGH, 8'h02);
    chk_rd(ADDR_IRQ_FLAGS_LOW, 8'h00);
    wr(ADDR_IRQ_MASK_LOW, 8'hfe);
    pulse(16'h0001);
    `CHK({irq_out, irq_oe_out}, 2'b11)
    wr(ADDR_GLOBAL_CONFIG, 8'h01);
    `CHK({irq_out, irq_oe_out}, 2'b01)
    wr(ADDR_GLOBAL_CONFIG, 8'h02);
    `CHK({irq_out, irq_oe_out}, 2'b01)
    chk_rd(ADDR_IRQ_FLAGS_LOW, 8'h01);
    repeat (3) @(posedge sys_clk_in);
    `CHK({irq_out, irq_oe_out}, 2'b00)
    wr(ADDR_GLOBAL_CONFIG, 8'h3d);
    `CHK({irq_out, irq_oe_out}, 2'b11)
    `CHK(path_out, ep(2'h3, 2'h3, 1'b1))
    path_mode_pins_in <= 2'h1;
    repeat (8) @(posedge sys_clk_in);
    `CHK(path_out, ep(2'h3, 2'h3, 1'b1))
    chk_rd(ADDR_GLOBAL_CONFIG, 8'h3d);
    boot(IF_M_STYLE);
    wr(ADDR_IRQ_MASK_HIGH, 8'h5a);
    chk_rd(ADDR_IRQ_MASK_HIGH, 8'h5a);
    boot(IF_SERIAL);
    for (int e = 0; e < 2; e++)
    begin
      shift_edge_sel_in <= e[0];
      wr(ADDR_IRQ_MASK_LOW, 8'h5a ^ {7'h00, e[0]});
      chk_rd(ADDR_IRQ_MASK_LOW, 8'h5a ^ {7'h00, e[0]});
    end
    h.ser(1'b1, 1'b1, ADDR_IRQ_MASK_LOW[6:0], 8'h00, q);
    chk_rd(ADDR_IRQ_MASK_LOW, 8'h5b);
    test_done();
  end
endmodule : lhcp_host_port_tb_top
